// [verilog/instr_decode_pkg.sv]
package instr_decode_pkg;
  localparam int INSTR_W = 14;
  localparam int FILE_W = 7;
  localparam int BIT_W = 3;
  localparam int PC_W = 13;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int FILE_LSB = 0;
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [6:0] STATUS_ADDR = 7'h03;
  localparam logic [6:0] PC_LOW_ADDR = 7'h02;
  localparam int Z_POS = 2;
  localparam int NIBBLE_CARRY_POS = 1;
  localparam int C_POS = 0;
  typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_BRANCH, CLS_LIT} class_e;
  typedef enum logic [2:0] {
    OP_NONE, OP_BCLR, OP_BSET, OP_BTSTC, OP_BTSTS, OP_CALL, OP_GOTO, OP_RET
  } op_e;
endpackage

// [verilog/instruction_field_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module instruction_field_decode (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Fetched word from program memory
  input wire logic [13:0] instr_word,
  // Datapath feedback for this instruction
  input wire logic skip_cond,
  input wire logic [7:0] file_rd_data,
  input wire logic [7:0] result_data,
  input wire logic [2:0] alu_flags,
  input wire logic [4:0] upper_address_holding_latch,
  // Decoded fields
  output logic [6:0] file_addr_q,
  output logic dest_file_q,
  output logic [2:0] bit_num_q,
  output logic [7:0] bit_mask_q,
  output logic [7:0] lit8_q,
  output logic [10:0] lit11_q,
  output logic [1:0] instr_class_q,
  // Timing and control
  output logic [1:0] phase_q,
  output logic cycle_start_q,
  output logic nop_cycle_q,
  // Write-back
  output logic wr_acc_q,
  output logic wr_file_q,
  output logic [7:0] wr_data_q,
  output logic pc_load_q,
  output logic [12:0] pc_load_value_q
);
  logic [1:0] phase_d;
  logic last_phase;
  logic two_cycle;
  logic [1:0] cls;
  logic [7:0] mask;
  logic [7:0] status_fix;
  logic [7:0] rmw;
  logic is_bitop;
  logic dst;
  logic file_wr;
  logic two_cycle_q;

  // Phase counter: four oscillator periods per instruction cycle
  assign phase_d = (phase_q == instr_decode_pkg::PHASE_LAST)
    ? instr_decode_pkg::PHASE_RST : phase_q + 2'h1;
  assign last_phase = phase_q == instr_decode_pkg::PHASE_LAST;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      phase_q <= instr_decode_pkg::PHASE_RST;
    else
      phase_q <= phase_d;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cycle_start_q <= 1'b0;
    else
      cycle_start_q <= last_phase;
  end

  // Class from top two bits; don't-care bits never inspected
  assign cls = instr_word[13:12];
  assign is_bitop = cls == 2'h1 && !instr_word[11];
  assign dst = instr_word[instr_decode_pkg::DEST_POS];
  // Branch, return or taken skip needs a second, no-op cycle
  assign two_cycle = cls == 2'h2 || skip_cond
    || (cls == 2'h3 && instr_word[11:10] == 2'h1)
    || (cls == 2'h0 && instr_word[11:1] == 11'h004);
  assign mask = 8'h01 << instr_word[9:7];
  // Bit operations rewrite the full byte
  assign rmw = instr_word[10] ? (file_rd_data | mask)
    : (file_rd_data & ~mask);
  assign file_wr = is_bitop || (cls == 2'h0 && dst);
  // Flags of any instruction but a bit set or clear win over written status bits
  always_comb
  begin
    status_fix = result_data;
    status_fix[instr_decode_pkg::Z_POS] = alu_flags[2];
    status_fix[instr_decode_pkg::NIBBLE_CARRY_POS] = alu_flags[1];
    status_fix[instr_decode_pkg::C_POS] = alu_flags[0];
  end

  // Field capture at end of each non-no-op cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      file_addr_q <= 7'h00;
      dest_file_q <= 1'b0;
      bit_num_q <= 3'h0;
      bit_mask_q <= 8'h00;
      lit8_q <= 8'h00;
      lit11_q <= 11'h000;
      instr_class_q <= 2'h0;
    end
    else if (last_phase && !two_cycle_q)
    begin
      file_addr_q <= instr_word[6:0];
      dest_file_q <= dst;
      bit_num_q <= instr_word[9:7];
      bit_mask_q <= mask;
      lit8_q <= instr_word[7:0];
      lit11_q <= instr_word[10:0];
      instr_class_q <= cls;
    end
  end

  // Second cycle of a two-cycle instruction runs as no-op
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      two_cycle_q <= 1'b0;
      nop_cycle_q <= 1'b0;
    end
    else if (last_phase)
    begin
      two_cycle_q <= !two_cycle_q && two_cycle;
      nop_cycle_q <= !two_cycle_q && two_cycle;
    end
  end

  // Write-back strobes, one clock at cycle end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_acc_q <= 1'b0;
      wr_file_q <= 1'b0;
      wr_data_q <= 8'h00;
      pc_load_q <= 1'b0;
      pc_load_value_q <= 13'h0000;
    end
    else
    begin
      wr_acc_q <= last_phase && !nop_cycle_q && cls == 2'h0 && !dst;
      wr_file_q <= last_phase && !nop_cycle_q && file_wr;
      if (is_bitop)
        wr_data_q <= rmw;
      else if (instr_word[6:0] == instr_decode_pkg::STATUS_ADDR)
        wr_data_q <= status_fix;
      else
        wr_data_q <= result_data;
      pc_load_q <= last_phase && !nop_cycle_q && file_wr
        && instr_word[6:0] == instr_decode_pkg::PC_LOW_ADDR;
      pc_load_value_q <= {upper_address_holding_latch,
        is_bitop ? rmw : result_data};
    end
  end

  // Assertions share the oscillator clock and reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Three quiet clocks, then the next cycle start
  sequence cycle_gap;
    !cycle_start_q [*3] ##1 cycle_start_q;
  endsequence

  // Capture edge of a fresh, non-refused word
  sequence fresh_capture;
    last_phase && !two_cycle_q;
  endsequence

  // Phase counter and cycle framing
  a_phase_wraps: assert property (
    phase_q == 2'h3 |=> phase_q == 2'h0)
    else $error("phase did not wrap after four clocks");
  a_cycle_period: assert property (
    cycle_start_q |=> cycle_gap)
    else $error("instruction cycle not four clocks");

  // No-op second cycle
  a_nop_one_cycle: assert property (
    nop_cycle_q && cycle_start_q |-> ##4 !nop_cycle_q)
    else $error("no-op cycle lasted more than one cycle");
  a_nop_no_write: assert property (
    last_phase && nop_cycle_q |=> !wr_file_q && !wr_acc_q && !pc_load_q)
    else $error("write during no-op cycle");
  a_skip_nop: assert property (
    last_phase && !two_cycle_q && skip_cond |=> nop_cycle_q)
    else $error("taken skip gave no no-op cycle");
  a_refused_word: assert property (
    last_phase && two_cycle_q |=> $stable(file_addr_q) && $stable(lit11_q))
    else $error("word taken during no-op cycle");

  // Field extraction
  a_file_capture: assert property (
    fresh_capture |=> file_addr_q == $past(instr_word[6:0]))
    else $error("file address not taken from word");
  a_lit_capture: assert property (
    fresh_capture |=> lit8_q == $past(instr_word[7:0])
      && lit11_q == $past(instr_word[10:0]))
    else $error("literal not taken from word");
  // Reset mask is zero, so only look once a word is in
  a_mask_onehot: assert property (
    cycle_start_q |-> bit_mask_q == (8'h01 << bit_num_q))
    else $error("bit mask does not match bit number");

  // Destination and write-back
  a_dest_exclusive: assert property (
    !(wr_acc_q && wr_file_q))
    else $error("both destinations written");
  a_acc_dest: assert property (
    wr_acc_q |-> !dest_file_q && instr_class_q == 2'h0)
    else $error("accumulator written without clear destination bit");
  a_status_fix: assert property (
    last_phase && !nop_cycle_q && !is_bitop
      && instr_word[6:0] == instr_decode_pkg::STATUS_ADDR
      |=> wr_data_q[2:0] == $past(alu_flags))
    else $error("status flags did not override written data");
  a_bit_rmw: assert property (
    last_phase && !nop_cycle_q && is_bitop |=> wr_file_q
      && ((wr_data_q ^ $past(file_rd_data)) & ~bit_mask_q) == 8'h00)
    else $error("bit operation changed other bits");
  a_strobe_pulse: assert property (
    wr_file_q |=> !wr_file_q)
    else $error("file write strobe longer than one clock");

  // Low counter byte writes
  a_pc_low_high: assert property (
    pc_load_q |-> pc_load_value_q[12:8] == $past(upper_address_holding_latch))
    else $error("high counter bits not from latch");
  a_pc_low_wr: assert property (
    pc_load_q |-> wr_file_q)
    else $error("counter load without file write");
endmodule
`default_nettype wire

// [test/fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  // Clock and phase
  input wire logic clock,
  input wire logic [1:0] phase_q,
  // Word queued by the bench
  input wire logic [13:0] next_word,
  // Fetch bus
  output logic [13:0] instr_word
);
  initial instr_word = 14'h0000;
  // Valid in phase 3 only, inverted otherwise
  always @(negedge clock)
  begin
    instr_word <= (phase_q == 2'h3) ? next_word : ~next_word;
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [13:0] word = 14'h0000;
  logic skip = 1'b0;
  logic [7:0] rd = 8'h00;
  logic [7:0] res = 8'h00;
  logic [2:0] flg = 3'h0;
  logic [4:0] latch = 5'h15;
  wire logic [13:0] iw;
  logic [6:0] fa;
  logic [2:0] bn;
  logic [7:0] bm, l8, wd;
  logic [10:0] l11;
  logic [1:0] cls, ph;
  logic df, cs, nop, wa, wf, pl;
  logic [12:0] pv;
  int fails = 0;
  int tests_run = 0;
  // Oscillator clock
  always #50 clock = ~clock;
  fetch_model fm (.clock(clock), .phase_q(ph), .next_word(word),
    .instr_word(iw));
  instruction_field_decode dut (.clock(clock), .rstn(rstn), .instr_word(iw),
    .skip_cond(skip), .file_rd_data(rd), .result_data(res), .alu_flags(flg),
    .upper_address_holding_latch(latch), .file_addr_q(fa), .dest_file_q(df),
    .bit_num_q(bn), .bit_mask_q(bm), .lit8_q(l8), .lit11_q(l11),
    .instr_class_q(cls), .phase_q(ph), .cycle_start_q(cs), .nop_cycle_q(nop),
    .wr_acc_q(wa), .wr_file_q(wf), .wr_data_q(wd), .pc_load_q(pl),
    .pc_load_value_q(pv));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Queue a word, return at the answer phase
  task automatic issue(input logic [13:0] w, input logic [7:0] r,
    input logic [7:0] s, input logic [2:0] f, input logic k);
    word = w;
    rd = r;
    res = s;
    flg = f;
    skip = k;
    @(negedge clock);
    while (ph !== 2'h3) @(negedge clock);
    @(negedge clock);
  endtask
  task t_byte;
    issue(14'h077F, 8'h00, 8'h5A, 3'h0, 1'b0);
    check({fa, df, wa, wf, cls}, {7'h7F, 3'b010, 2'h0});
    issue(14'h0780, 8'h00, 8'hC3, 3'h0, 1'b0);
    check({fa, wa, wf, wd}, {7'h00, 2'b01, 8'hC3});
    @(negedge clock);
    check({wa, wf}, 2'h0);
  endtask
  task t_special;
    issue(14'h0083, 8'h00, 8'hFF, 3'h2, 1'b0);
    check({wf, wd}, {1'b1, 8'hFA});
    issue(14'h0882, 8'h00, 8'h3C, 3'h0, 1'b0);
    check({pl, pv}, {1'b1, 13'h153C});
  endtask
  task t_bit;
    issue(14'h1790, 8'h00, 8'h00, 3'h0, 1'b0);
    check({wf, bn, bm, wd}, {1'b1, 3'h7, 8'h80, 8'h80});
    issue(14'h1010, 8'hFF, 8'h00, 3'h0, 1'b0);
    check({wf, bn, bm, wd}, {1'b1, 3'h0, 8'h01, 8'hFE});
  endtask
  task t_phase;
    for (int i = 0; i < 8; i++)
    begin
      check({ph, cs}, {i[1:0], i[1:0] == 2'h0});
      @(negedge clock);
    end
  endtask
  task t_two;
    issue(14'h30A5, 8'h00, 8'h00, 3'h0, 1'b0);
    check({cls, l8, nop}, {2'h3, 8'hA5, 1'b0});
    issue(14'h2ABC, 8'h00, 8'h00, 3'h0, 1'b0);
    check({cls, l11, nop}, {2'h2, 11'h2BC, 1'b1});
    issue(14'h0780, 8'h00, 8'h11, 3'h0, 1'b0);
    check({nop, wf, fa, l8}, {2'b00, 7'h3C, 8'hBC});
    issue(14'h0B80, 8'h00, 8'h00, 3'h0, 1'b1);
    check({nop, wf}, 2'b11);
    // Let the no-op cycle pass before the next word
    repeat (4) @(negedge clock);
    issue(14'h3755, 8'h00, 8'h00, 3'h0, 1'b0);
    check({cls, l8, nop}, {2'h3, 8'h55, 1'b1});
    repeat (4) @(negedge clock);
    issue(14'h0008, 8'h00, 8'h00, 3'h0, 1'b0);
    check({cls, nop, wf}, {2'h0, 2'b10});
  endtask
  // Reset in the first clock of a no-op cycle, then restart
  task t_reset;
    rstn = 1'b0;
    @(negedge clock);
    check({ph, cs, nop, wa, wf, pl}, 7'h00);
    check({fa, df, bn, bm, cls}, 21'h000000);
    check({l8, l11, wd}, 27'h0000000);
    check(pv, 13'h0000);
    rstn = 1'b1;
    @(negedge clock);
    check({ph, cs}, 3'b010);
    issue(14'h0780, 8'h00, 8'h5A, 3'h0, 1'b0);
    check({ph, cs, wf, wd}, {2'h0, 2'b11, 8'h5A});
  endtask
  task final_report;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    fails++;
    final_report;
  end
  // Main sequence
  initial
  begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    t_byte;
    t_special;
    t_bit;
    t_phase;
    t_two;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
